// File: rtl/mag_pkg.sv
// Purpose: Constants and types for the mode-aware address generator.
// Assumes: One core clock; requests come from the decoder and execution pipeline.
// Notes:   The widths of the canonical check follow the implemented linear width.
//
// Behaviour
// [R1] 64-bit mode: core segments have zero base
// [R2] 32-bit protected addressing caps at FFFFFFFFh
// [R3] 16-bit protected addressing caps at FFFFh
// [R4] Logical address is selector plus sized offset
// [R5] Protected default sizes come from code descriptor
// [R6] Prefix overrides size for one instruction only
// [R7] Real mode 16-bit default, limit 000FFFFFh
// [R8] 64-bit EA: 64-bit base, index, sign-extended displacement
// [R9] Truncate EA first, then add full base
// [R10] Pointer sizing: 16 keeps upper, 32 zero-extends
// [R11] Displacements 32-bit signed except data transfer
// [R12] Long mode: 16/32-bit results zero-extend to 64
// [R13] Canonical: upper bits all equal implemented top
// [R14] 48-bit: bits 63..48 equal bit 47
// [R15] Non-canonical reference raises general protection fault
// [R16] Non-canonical stack reference raises stack fault
// [R17] Push, pop and stack-based bases use stack segment
// [R18] Stack base with aux override raises general protection
// [R19] 64-bit mode ignores core segment overrides
// [R20] No segmented or real model in 64-bit mode
// [R21] System management mode uses its own address space
// [R22] Wide physical addressing only in protected paging
// [R23] Paging off: physical equals linear
// [R24] Request carries mode and ids; answer carries fault
package mag_pkg;

  // ****************************************************************
  // Widths and limits
  // ****************************************************************
  localparam int             MAG_AW        = 64;
  localparam int             MAG_LIN_IMPL  = 48;
  localparam int             MAG_PHYS_W    = 36;
  localparam logic [63:0]    MAG_LIM_16    = 64'h0000_0000_0000_ffff;
  localparam logic [63:0]    MAG_LIM_32    = 64'h0000_0000_ffff_ffff;
  localparam logic [63:0]    MAG_LIM_REAL  = 64'h0000_0000_000f_ffff;
  localparam logic [63:0]    MAG_LIM_PHYS  = 64'h0000_000f_ffff_ffff;
  localparam logic [3:0]     MAG_SHIFT_RM  = 4'h4;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    MAG_MODE_REAL,
    MAG_MODE_PROT,
    MAG_MODE_MGMT,
    MAG_MODE_COMPAT,
    MAG_MODE_LONG64
  } mag_mode_t;

  typedef enum logic [1:0] {
    MAG_SZ_16,
    MAG_SZ_32,
    MAG_SZ_64
  } mag_size_t;

  typedef enum logic [2:0] {
    MAG_SEG_CODE,
    MAG_SEG_DATA,
    MAG_SEG_EXTRA,
    MAG_SEG_STACK,
    MAG_SEG_AUXF,
    MAG_SEG_AUXG
  } mag_seg_t;

  typedef enum logic [1:0] {
    MAG_BASE_OTHER,
    MAG_BASE_STACKPTR,
    MAG_BASE_FRAME
  } mag_basereg_t;

  typedef enum logic [1:0] {
    MAG_FLT_NONE,
    MAG_FLT_GP,
    MAG_FLT_SS
  } mag_fault_t;

  typedef enum logic [1:0] {
    MAG_IP_KEEP,
    MAG_IP_LOAD16,
    MAG_IP_LOAD32,
    MAG_IP_LOAD64
  } mag_ipop_t;

endpackage

// File: rtl/mag_canon_if.sv
`timescale 1ns/10ps
// Purpose: Carries one linear address to the canonical checker and its verdict back.
// Assumes: Purely combinational link inside one clock domain.
// Notes:   Used only between the address generator and its checker.
interface mag_canon_if;
  logic [63:0] lin_addr;
  logic        canon_ok;

  modport gen (output lin_addr, input  canon_ok);
  modport chk (input  lin_addr, output canon_ok);
endinterface

// File: rtl/mag_canon_chk.sv
`timescale 1ns/10ps
// Purpose: Canonical form check of a linear address.
// Assumes: IMPL_W is the implemented linear width, below 64.
// Notes:   Combinational; the generator registers the verdict.
module mag_canon_chk #(
  parameter int IMPL_W = 48
) (
  // Address in, verdict out
  mag_canon_if.chk cif
);
  import mag_pkg::*;

  // Bits 63 down to the top implemented bit must all agree.
  assign cif.canon_ok = (&cif.lin_addr[63:IMPL_W-1]) |      // R13 R14
                        ~(|cif.lin_addr[63:IMPL_W-1]);      // R13 R14
endmodule // mag_canon_chk

// File: rtl/mag_addr_gen.sv
`timescale 1ns/10ps
// Purpose: Mode-aware effective, linear and physical address generation.
// Assumes: The pipeline holds segment bases and code descriptor size bits and
//          presents one request per valid cycle; paging sits downstream.
// Notes:   One cycle of latency; every request is answered, there is no stall.
module mag_addr_gen
  import mag_pkg::*;
#(
  parameter int LIN_IMPL_W = mag_pkg::MAG_LIN_IMPL
) (
  // Clock and reset
  input  wire logic                  mclk_i,
  input  wire logic                  nrst_i,
  // Mode and defaults
  input  wire mag_pkg::mag_mode_t    mode_i,
  input  wire logic                  cs_default_32_i,
  input  wire logic                  cs_long_i,
  input  wire logic                  paging_en_i,
  // Segment bases held by the pipeline
  input  wire logic [63:0]           seg_base_code_i,
  input  wire logic [63:0]           seg_base_data_i,
  input  wire logic [63:0]           seg_base_extra_i,
  input  wire logic [63:0]           seg_base_stack_i,
  input  wire logic [63:0]           seg_base_auxf_i,
  input  wire logic [63:0]           seg_base_auxg_i,
  input  wire logic [63:0]           mgmt_base_i,
  // Address request
  input  wire logic                  req_valid_i,
  input  wire logic                  asz_override_i,
  input  wire logic                  osz_override_i,
  input  wire logic                  seg_override_i,
  input  wire mag_pkg::mag_seg_t     seg_sel_i,
  input  wire mag_pkg::mag_basereg_t base_id_i,
  input  wire logic                  stack_op_i,
  input  wire logic                  data_xfer_i,
  input  wire logic                  base_en_i,
  input  wire logic [63:0]           base_val_i,
  input  wire logic                  index_en_i,
  input  wire logic [63:0]           index_val_i,
  input  wire logic [1:0]            scale_i,
  input  wire logic [63:0]           disp_i,
  input  wire logic [15:0]           selector_i,
  // Address answer
  output logic                       ans_valid_o,
  output logic [63:0]                eff_addr_o,
  output logic [63:0]                lin_addr_o,
  output logic [63:0]                phys_addr_o,
  output logic                       phys_direct_o,
  output logic [15:0]                selector_o,
  output mag_pkg::mag_seg_t          seg_used_o,
  output mag_pkg::mag_size_t         addr_size_o,
  output mag_pkg::mag_size_t         oper_size_o,
  output logic                       mgmt_sel_o,
  output logic                       fault_o,
  output mag_pkg::mag_fault_t        fault_type_o,
  // Instruction pointer
  input  wire mag_pkg::mag_ipop_t    ip_op_i,
  input  wire logic [63:0]           ip_new_i,
  output logic [63:0]                insn_pointer_64_o
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Cuts a value down to the given address size, zero above.
  function automatic logic [63:0] mag_trunc(input logic [63:0] v, input mag_size_t s);
    case (s)
      MAG_SZ_16: mag_trunc = v & MAG_LIM_16;
      MAG_SZ_32: mag_trunc = v & MAG_LIM_32;
      default:   mag_trunc = v;
    endcase
  endfunction

  // Sign-extends the low 32 bits of a value to 64.
  function automatic logic [63:0] mag_sext32(input logic [63:0] v);
    mag_sext32 = {{32{v[31]}}, v[31:0]};
  endfunction

  // ****************************************************************
  // Size selection
  // ****************************************************************
  mag_size_t asz_c;
  mag_size_t osz_c;
  logic      in64_c;

  assign in64_c = (mode_i == MAG_MODE_LONG64) && cs_long_i;

  // The override flips the size for this request only; nothing is stored.
  always_comb begin
    case (mode_i)
      MAG_MODE_LONG64: begin
        asz_c = asz_override_i ? MAG_SZ_32 : MAG_SZ_64;               // R6 R8
        osz_c = osz_override_i ? MAG_SZ_16 : MAG_SZ_32;
      end
      MAG_MODE_PROT,
      MAG_MODE_COMPAT: begin
        // Default sizes follow the running code segment descriptor.
        asz_c = (cs_default_32_i ^ asz_override_i) ? MAG_SZ_32 : MAG_SZ_16;   // R5 R6
        osz_c = (cs_default_32_i ^ osz_override_i) ? MAG_SZ_32 : MAG_SZ_16;   // R5 R6
      end
      default: begin
        asz_c = asz_override_i ? MAG_SZ_32 : MAG_SZ_16;               // R7 R6
        osz_c = osz_override_i ? MAG_SZ_32 : MAG_SZ_16;               // R7
      end
    endcase
  end

  // ****************************************************************
  // Segment choice
  // ****************************************************************
  mag_seg_t seg_c;
  logic     stack_ref_c;
  logic     stack_base_c;

  assign stack_base_c = base_en_i &&
                        ((base_id_i == MAG_BASE_STACKPTR) || (base_id_i == MAG_BASE_FRAME));

  always_comb begin
    seg_c = (stack_op_i || stack_base_c) ? MAG_SEG_STACK : MAG_SEG_DATA;   // R17
    if (seg_override_i) begin
      if (in64_c) begin
        // Only the two auxiliary overrides survive in 64-bit mode.
        if ((seg_sel_i == MAG_SEG_AUXF) || (seg_sel_i == MAG_SEG_AUXG)) begin
          seg_c = seg_sel_i;                                          // R19
        end
      end else begin
        seg_c = seg_sel_i;
      end
    end
  end

  // A stack override on a non-stack register does not make it a stack reference.
  assign stack_ref_c = (stack_op_i || stack_base_c) && (seg_c == MAG_SEG_STACK);   // R18 R19

  // ****************************************************************
  // Segment base
  // ****************************************************************
  logic [63:0] seg_base_c;

  always_comb begin
    case (seg_c)
      MAG_SEG_CODE:  seg_base_c = seg_base_code_i;
      MAG_SEG_EXTRA: seg_base_c = seg_base_extra_i;
      MAG_SEG_STACK: seg_base_c = seg_base_stack_i;
      MAG_SEG_AUXF:  seg_base_c = seg_base_auxf_i;
      MAG_SEG_AUXG:  seg_base_c = seg_base_auxg_i;
      default:       seg_base_c = seg_base_data_i;
    endcase
    if (in64_c && (seg_c != MAG_SEG_AUXF) && (seg_c != MAG_SEG_AUXG)) begin
      seg_base_c = '0;                                                // R1 R20
    end else if (!in64_c && (mode_i != MAG_MODE_MGMT)) begin
      seg_base_c = seg_base_c & MAG_LIM_32;
    end
  end

  // ****************************************************************
  // Effective address
  // ****************************************************************
  logic [63:0] disp_c;
  logic [63:0] index_c;
  logic [63:0] ea_sum_c;
  logic [63:0] ea_c;
  logic [63:0] lin_c;
  logic        limit_err_c;

  // Only the data transfer form may carry a full 64-bit displacement.
  assign disp_c   = (in64_c && data_xfer_i) ? disp_i : mag_sext32(disp_i);   // R8 R11
  assign index_c  = index_en_i ? (index_val_i << scale_i) : '0;
  assign ea_sum_c = (base_en_i ? base_val_i : '0) + index_c + disp_c;        // R8
  // Truncating before the base is added keeps the 16-bit and 32-bit wrap.
  assign ea_c     = mag_trunc(ea_sum_c, asz_c);                   // R4 R9 R12 R2 R3

  always_comb begin
    limit_err_c = 1'b0;
    case (mode_i)
      MAG_MODE_LONG64: begin
        lin_c = ea_c + seg_base_c;                                    // R9
      end
      MAG_MODE_COMPAT: begin
        lin_c = mag_trunc(ea_c + seg_base_c, MAG_SZ_32);              // R12
      end
      MAG_MODE_PROT: begin
        lin_c = mag_trunc(ea_c + seg_base_c, MAG_SZ_32);              // R2 R22
      end
      MAG_MODE_MGMT: begin
        // Addressed like real mode but relative to the private RAM base.
        lin_c = mgmt_base_i + ea_c + ({48'h0, selector_i} << MAG_SHIFT_RM);   // R21
      end
      default: begin
        lin_c = ea_c + ({48'h0, selector_i} << MAG_SHIFT_RM);         // R20
        limit_err_c = (lin_c > MAG_LIM_REAL);                         // R7
        lin_c = lin_c & MAG_LIM_REAL;                                 // R7
      end
    endcase
  end

  // ****************************************************************
  // Canonical check
  // ****************************************************************
  mag_canon_if cif ();

  assign cif.lin_addr = lin_c;

  mag_canon_chk #(
    .IMPL_W (LIN_IMPL_W)
  ) u_canon (
    .cif (cif.chk)
  );

  mag_fault_t fault_c;

  always_comb begin
    fault_c = MAG_FLT_NONE;
    if (in64_c && !cif.canon_ok) begin
      fault_c = stack_ref_c ? MAG_FLT_SS : MAG_FLT_GP;                // R15 R16 R17 R18
    end else if (limit_err_c) begin
      fault_c = stack_ref_c ? MAG_FLT_SS : MAG_FLT_GP;
    end
  end

  // ****************************************************************
  // Answer registers
  // ****************************************************************
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ans_valid_o <= 1'b0;
    end else begin
      ans_valid_o <= req_valid_i;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      eff_addr_o    <= '0;
      lin_addr_o    <= '0;
      phys_addr_o   <= '0;
      phys_direct_o <= 1'b0;
      selector_o    <= '0;
      seg_used_o    <= MAG_SEG_DATA;
      addr_size_o   <= MAG_SZ_16;
      oper_size_o   <= MAG_SZ_16;
      mgmt_sel_o    <= 1'b0;
      fault_o       <= 1'b0;
      fault_type_o  <= MAG_FLT_NONE;
    end else if (req_valid_i) begin
      eff_addr_o    <= ea_c;
      lin_addr_o    <= lin_c;
      // Without paging the linear address goes out masked to 36 bits; the wide physical
      // range exists only through paging, which translates downstream.
      phys_addr_o   <= (lin_c & MAG_LIM_PHYS);                        // R23 R22
      phys_direct_o <= !paging_en_i;                                  // R23
      selector_o    <= selector_i;                                    // R4
      seg_used_o    <= seg_c;
      addr_size_o   <= asz_c;
      oper_size_o   <= osz_c;
      mgmt_sel_o    <= (mode_i == MAG_MODE_MGMT);                     // R21
      fault_o       <= (fault_c != MAG_FLT_NONE);                     // R24
      fault_type_o  <= fault_c;                                       // R24
    end
  end

  // ****************************************************************
  // Instruction pointer
  // ****************************************************************
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      insn_pointer_64_o <= '0;
    end else begin
      case (ip_op_i)
        MAG_IP_LOAD16: insn_pointer_64_o[15:0] <= ip_new_i[15:0];     // R10
        MAG_IP_LOAD32: insn_pointer_64_o <= {32'h0, ip_new_i[31:0]};  // R10
        MAG_IP_LOAD64: insn_pointer_64_o <= ip_new_i;                 // R10
        default:       insn_pointer_64_o <= insn_pointer_64_o;
      endcase
    end
  end

endmodule // mag_addr_gen

// File: verification/mag_addr_gen_props.sv
// Purpose: Concurrent checks on the ports of the address generator.
// Assumes: One clock; every answer comes one cycle after its request.
// Notes:   Helper registers keep the request context for the answer cycle.
`timescale 1ns/10ps
module mag_addr_gen_props #(
  parameter int LIN_IMPL_W = 48
) (
  // Clock and reset
  input wire logic                  mclk_i,
  input wire logic                  nrst_i,
  // Request side
  input wire mag_pkg::mag_mode_t    mode_i,
  input wire logic                  cs_long_i,
  input wire logic                  req_valid_i,
  input wire mag_pkg::mag_ipop_t    ip_op_i,
  input wire logic [63:0]           ip_new_i,
  // Answer side
  input wire logic                  ans_valid_o,
  input wire logic [63:0]           eff_addr_o,
  input wire logic [63:0]           lin_addr_o,
  input wire logic [63:0]           phys_addr_o,
  input wire logic                  phys_direct_o,
  input wire mag_pkg::mag_seg_t     seg_used_o,
  input wire logic                  mgmt_sel_o,
  input wire logic                  fault_o,
  input wire mag_pkg::mag_fault_t   fault_type_o,
  input wire logic [63:0]           insn_pointer_64_o
);
  import mag_pkg::*;
  localparam logic [63:0] HI_ONES = {64{1'b1}} >> (LIN_IMPL_W - 1);
  logic [63:0] hi;
  logic [63:0] ipn_q;
  logic [63:0] ipp_q;
  mag_mode_t   mq;
  logic        lq;

  // A non-canonical address leaves bits 63 down to the implemented top unequal.
  assign hi = lin_addr_o >> (LIN_IMPL_W - 1);

  always_ff @(posedge mclk_i) begin
    ipn_q <= ip_new_i;
    ipp_q <= insn_pointer_64_o;
    mq    <= mode_i;
    lq    <= (mode_i == MAG_MODE_LONG64) && cs_long_i;
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  AST_ANS_NEXT: assert property (req_valid_i |=> ans_valid_o)
    else $error("answer missing after request");
  AST_ANS_ONLY: assert property (!req_valid_i |=> !ans_valid_o)
    else $error("answer without request");
  AST_FLT_ONE: assert property (ans_valid_o |-> fault_o == (fault_type_o != MAG_FLT_NONE))
    else $error("fault flag and type disagree");
  AST_LONG_FLAT: assert property (ans_valid_o && lq && seg_used_o inside {MAG_SEG_CODE,
    MAG_SEG_DATA, MAG_SEG_EXTRA, MAG_SEG_STACK} |-> lin_addr_o == eff_addr_o)
    else $error("core segment base not zero in 64-bit mode");
  AST_PROT_CAP: assert property (ans_valid_o && mq inside {MAG_MODE_PROT, MAG_MODE_COMPAT}
    |-> lin_addr_o[63:32] == 32'h0)
    else $error("linear address above 32 bits");
  AST_REAL_CAP: assert property (ans_valid_o && mq == MAG_MODE_REAL |-> lin_addr_o[63:20] == 0)
    else $error("real-mode linear address above 20 bits");
  AST_CANON: assert property (ans_valid_o && lq |-> fault_o == !(hi == 0 || hi == HI_ONES))
    else $error("canonical verdict wrong");
  AST_SS_STACK: assert property (ans_valid_o && fault_type_o == MAG_FLT_SS
    |-> seg_used_o == MAG_SEG_STACK)
    else $error("stack fault outside stack segment");
  AST_MGMT_SEL: assert property (ans_valid_o |-> mgmt_sel_o == (mq == MAG_MODE_MGMT))
    else $error("management space select wrong");
  AST_PHYS: assert property (ans_valid_o && phys_direct_o
    |-> phys_addr_o == (lin_addr_o & MAG_LIM_PHYS))
    else $error("direct physical address differs");
  AST_IP16: assert property (ip_op_i == MAG_IP_LOAD16
    |=> insn_pointer_64_o == {ipp_q[63:16], ipn_q[15:0]})
    else $error("16-bit pointer load wrong");
  AST_IP32: assert property (ip_op_i == MAG_IP_LOAD32
    |=> insn_pointer_64_o == {32'h0, ipn_q[31:0]})
    else $error("32-bit pointer load wrong");

  cover property (ans_valid_o && fault_type_o == MAG_FLT_SS);
  cover property (ans_valid_o && fault_type_o == MAG_FLT_GP);
  cover property (ans_valid_o && mgmt_sel_o);
endmodule // mag_addr_gen_props

bind mag_addr_gen mag_addr_gen_props #(.LIN_IMPL_W(LIN_IMPL_W)) u_props (
  .mclk_i(mclk_i), .nrst_i(nrst_i), .mode_i(mode_i), .cs_long_i(cs_long_i),
  .req_valid_i(req_valid_i), .ip_op_i(ip_op_i), .ip_new_i(ip_new_i),
  .ans_valid_o(ans_valid_o), .eff_addr_o(eff_addr_o), .lin_addr_o(lin_addr_o),
  .phys_addr_o(phys_addr_o), .phys_direct_o(phys_direct_o), .seg_used_o(seg_used_o),
  .mgmt_sel_o(mgmt_sel_o), .fault_o(fault_o), .fault_type_o(fault_type_o),
  .insn_pointer_64_o(insn_pointer_64_o));

// File: verification/mag_pipe_model.sv
// Purpose: Pipeline side that presents address requests to the generator.
// Assumes: Requests change on the falling edge and last one cycle.
// Notes:   Operand lines are inverted once released so stale values never match.
`timescale 1ns/10ps
module mag_pipe_model (
  // Clock
  input  wire logic          mclk_i,
  // Request
  output logic               req_valid_o,
  output mag_pkg::mag_mode_t mode_o,
  output logic               asz_o,
  output logic               ovr_o,
  output mag_pkg::mag_seg_t  seg_o,
  output mag_pkg::mag_basereg_t bid_o,
  output logic               stk_o,
  output logic               xfer_o,
  output logic [63:0]        base_o,
  output logic [63:0]        idx_o,
  output logic [63:0]        disp_o
);
  import mag_pkg::*;
  initial begin
    req_valid_o = 1'b0;
    {asz_o, ovr_o, stk_o, xfer_o} = 4'h0;
    {base_o, idx_o, disp_o} = '0;
    mode_o = MAG_MODE_REAL;
    seg_o = MAG_SEG_DATA;
    bid_o = MAG_BASE_OTHER;
  end

  // One request, held for exactly the edge that takes it.
  task automatic send(input mag_mode_t m, input logic a, o, input mag_seg_t s,
                      input mag_basereg_t b, input logic st, x, input logic [63:0] bv, iv, dv);
    @(negedge mclk_i);
    mode_o = m;
    {asz_o, ovr_o, stk_o, xfer_o} = {a, o, st, x};
    seg_o = s;
    bid_o = b;
    {base_o, idx_o, disp_o} = {bv, iv, dv};
    req_valid_o = 1'b1;
    @(negedge mclk_i);
    req_valid_o = 1'b0;
    {base_o, idx_o, disp_o} = ~{base_o, idx_o, disp_o};
  endtask
endmodule // mag_pipe_model

// File: verification/mag_addr_gen_test.sv
// Purpose: Self-checking bench for the mode-aware address generator.
// Assumes: Index is always scaled by two; operand-size prefix only in protected mode.
// Notes:   Expected addresses are worked out by hand for each case.
`timescale 1ns/10ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module mag_addr_gen_test;
  import mag_pkg::*;
  logic         mclk_i, nrst_i, cs32, csl, pg, rv, asz, osz, ovr, stk, xfr, av, pd, sm, flt;
  logic [63:0]  bs [7];
  logic [63:0]  bv, iv, dv, ea, la, pa, ipn, ip;
  logic [15:0]  sel, selo;
  mag_mode_t    md;
  mag_seg_t     sg, su;
  mag_basereg_t bid;
  mag_size_t    asize, osize;
  mag_fault_t   ft;
  mag_ipop_t    ipop;
  int           n_fail, cmp_count;

  mag_pipe_model pm (.mclk_i(mclk_i), .req_valid_o(rv), .mode_o(md), .asz_o(asz),
    .ovr_o(ovr), .seg_o(sg), .bid_o(bid), .stk_o(stk), .xfer_o(xfr), .base_o(bv),
    .idx_o(iv), .disp_o(dv));
  mag_addr_gen #(.LIN_IMPL_W(48)) DUT (.mclk_i(mclk_i), .nrst_i(nrst_i), .mode_i(md),
    .cs_default_32_i(cs32), .cs_long_i(csl), .paging_en_i(pg), .seg_base_code_i(bs[0]),
    .seg_base_data_i(bs[1]), .seg_base_extra_i(bs[2]), .seg_base_stack_i(bs[3]),
    .seg_base_auxf_i(bs[4]), .seg_base_auxg_i(bs[5]), .mgmt_base_i(bs[6]),
    .req_valid_i(rv), .asz_override_i(asz), .osz_override_i(osz), .seg_override_i(ovr),
    .seg_sel_i(sg), .base_id_i(bid), .stack_op_i(stk), .data_xfer_i(xfr), .base_en_i(1'b1),
    .base_val_i(bv), .index_en_i(1'b1), .index_val_i(iv), .scale_i(2'h1), .disp_i(dv),
    .selector_i(sel), .ans_valid_o(av), .eff_addr_o(ea), .lin_addr_o(la), .phys_addr_o(pa),
    .phys_direct_o(pd), .selector_o(selo), .seg_used_o(su), .addr_size_o(asize),
    .oper_size_o(osize), .mgmt_sel_o(sm), .fault_o(flt), .fault_type_o(ft), .ip_op_i(ipop),
    .ip_new_i(ipn),
    .insn_pointer_64_o(ip));

  // ****************************************************************
  // Shared checks
  // ****************************************************************
  task automatic chk_ans(input logic [63:0] e_la, input mag_fault_t e_ft);
    `CHK("valid", 1'b1, av)
    `CHK("lin", e_la, la)
    `CHK("ftype", e_ft, ft)
    `CHK("fault", e_ft != MAG_FLT_NONE, flt)
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_long;
    csl = 1'b1;
    pm.send(MAG_MODE_LONG64, 0, 1, MAG_SEG_DATA, MAG_BASE_OTHER, 0, 0,
            64'h0000_7fff_ffff_0000, 64'h8, 64'h0000_0000_ffff_fff0);
    chk_ans(64'h0000_7fff_ffff_0000, MAG_FLT_NONE);
    pm.send(MAG_MODE_LONG64, 0, 0, MAG_SEG_DATA, MAG_BASE_OTHER, 0, 1,
            64'h0000_7fff_ffff_0000, 64'h8, 64'h0000_0000_ffff_fff0);
    chk_ans(64'h0000_8000_ffff_0000, MAG_FLT_GP);
    pm.send(MAG_MODE_LONG64, 1, 1, MAG_SEG_AUXF, MAG_BASE_OTHER, 0, 0,
            64'hffff_fff0, 64'h10, 64'h0);
    chk_ans(64'h1_0000_0010, MAG_FLT_NONE);
    `CHK("ea32", 64'h10, ea)
  endtask

  task automatic t_canon;
    logic [63:0]  bt [5] = '{64'h0000_8000_0000_0000, 64'h0000_8000_0000_0000,
      64'h0000_7fff_0000_0000, 64'h0000_8000_0000_0000, 64'hffff_8000_0000_0000};
    mag_basereg_t rt [5] = '{MAG_BASE_OTHER, MAG_BASE_STACKPTR, MAG_BASE_FRAME,
      MAG_BASE_OTHER, MAG_BASE_OTHER};
    mag_seg_t     st [5] = '{MAG_SEG_DATA, MAG_SEG_DATA, MAG_SEG_AUXF, MAG_SEG_STACK,
      MAG_SEG_DATA};
    mag_fault_t   fe [5] = '{MAG_FLT_SS, MAG_FLT_SS, MAG_FLT_GP, MAG_FLT_GP, MAG_FLT_NONE};
    for (int i = 0; i < 5; i++) begin
      pm.send(MAG_MODE_LONG64, 0, i[1], st[i], rt[i], i == 0 || i == 4, 0, bt[i], 0, 0);
      chk_ans(i == 2 ? 64'h0000_8000_0000_0000 : bt[i], fe[i]);
    end
  endtask

  task t_prot;
    csl = 1'b0;
    for (int i = 0; i < 4; i++) begin
      cs32 = (i == 3);
      osz = (i == 2);
      pm.send(MAG_MODE_PROT, i == 1, 0, MAG_SEG_DATA, MAG_BASE_OTHER, 0, 0,
              i == 3 ? 64'hffff_fffe : 64'hfffe, 64'h1, 64'h0);
      chk_ans((i == 1 ? 64'h1_0000 : 64'h0) + 64'h1000, MAG_FLT_NONE);
      `CHK("asize", (i == 1 || i == 3) ? MAG_SZ_32 : MAG_SZ_16, asize)
      `CHK("osize", (i == 2 || i == 3) ? MAG_SZ_32 : MAG_SZ_16, osize)
    end
  endtask

  task t_real;
    sel = 16'hffff;
    for (int i = 0; i < 2; i++) begin
      pm.send(MAG_MODE_REAL, 0, 0, MAG_SEG_DATA, MAG_BASE_OTHER, 0, 0, 64'hf + i, 0, 0);
      chk_ans(i ? 64'h0 : 64'hf_ffff, i ? MAG_FLT_GP : MAG_FLT_NONE);
      `CHK("rsize", MAG_SZ_16, asize)
    end
  endtask

  task t_mgmt;
    sel = 16'h0010;
    pg = 1'b0;
    pm.send(MAG_MODE_MGMT, 0, 0, MAG_SEG_DATA, MAG_BASE_OTHER, 0, 0, 64'h20, 0, 0);
    chk_ans(64'h3000_0120, MAG_FLT_NONE);
    `CHK("mgmt_space", 1'b1, sm)
    `CHK("selector", 16'h0010, selo)
    `CHK("direct", 1'b1, pd)
    `CHK("phys", 64'h3000_0120, pa)
  endtask

  task t_ip;
    @(negedge mclk_i);
    ipop = MAG_IP_LOAD64;
    ipn = 64'hfedc_ba98_7654_3210;
    @(negedge mclk_i);
    `CHK("ip64", 64'hfedc_ba98_7654_3210, ip)
    ipop = MAG_IP_LOAD16;
    ipn = 64'h1111_1111_1111_abcd;
    @(negedge mclk_i);
    `CHK("ip16", 64'hfedc_ba98_7654_abcd, ip)
    ipop = MAG_IP_LOAD32;
    ipn = 64'h2222_2222_89ab_cdef;
    @(negedge mclk_i);
    `CHK("ip32", 64'h0000_0000_89ab_cdef, ip)
    ipop = MAG_IP_KEEP;
  endtask

  task end_of_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  // The whole run needs well under two hundred cycles.
  initial begin
    #200000;
    n_fail++;
    end_of_test;
  end

  initial begin
    {nrst_i, cs32, csl, pg, osz, sel, ipn} = '0;
    ipop = MAG_IP_KEEP;
    pg = 1'b1;
    bs = '{64'h5000, 64'h0000_0001_0000_1000, 64'h6000, 64'h7000, 64'h1_0000_0000,
           64'h8000, 64'h3000_0000};
    repeat (4) @(posedge mclk_i);
    @(negedge mclk_i);
    `CHK("rst_valid", 1'b0, av)
    nrst_i = 1'b1;
    t_long;
    t_canon;
    t_prot;
    t_real;
    t_mgmt;
    t_ip;
    end_of_test;
  end
endmodule // mag_addr_gen_test
